// ### common/gcd_pkg.sv
// constants and types shared by the command decoder
package gcd_pkg;
  localparam int DATA_W = 8;
  localparam int CODE_W = 7;
  localparam int ADDR_W = 5;
  localparam int FIFO_DEPTH = 4;
  localparam logic [4:0] ADDR_MAX = 5'h1E;
  localparam logic [6:0] CMD_GO_LOCAL = 7'h01;
  localparam logic [6:0] CMD_SEL_CLEAR = 7'h04;
  localparam logic [6:0] CMD_TRIGGER = 7'h08;
  localparam logic [6:0] CMD_LOCKOUT = 7'h11;
  localparam logic [6:0] CMD_DEV_CLEAR = 7'h14;
  localparam logic [6:0] CMD_POLL_ON = 7'h18;
  localparam logic [6:0] CMD_POLL_OFF = 7'h19;
  localparam logic [6:0] CMD_UNLISTEN = 7'h3F;
  localparam logic [6:0] CMD_UNTALK = 7'h5F;
  localparam logic [6:0] LISTEN_BASE = 7'h20;
  localparam logic [6:0] TALK_BASE = 7'h40;
  localparam logic [1:0] GRP_LISTEN = 2'h1;
  localparam logic [1:0] GRP_TALK = 2'h2;
  typedef enum logic [1:0] {
    GCD_HS_IDLE = 2'h0,
    GCD_HS_READY = 2'h1,
    GCD_HS_TAKEN = 2'h3
  } gcd_hs_t;
endpackage

// ### design/gcd_decoder.sv
// bus command decoder, acceptor handshake and data path for an instrument
// Notes on behaviour
// - uniline commands are read purely from the level of their own bus line
// - controller drives ATN IFC REN; we only drive SRQ, NRFD, NDAC
// - asserted REN puts the device into remote operation
// - EOI travelling with the last data byte marks message end
// - IFC drops both talker and listener roles at once
// - ATN low bytes are commands; ATN high bytes are device data
// - device pulls SRQ low while it needs service and is not in serial poll
// - universal commands act without addressing whenever ATN is low
// - byte 0x11 under ATN enables front-panel lockout
// - byte 0x14 under ATN pulses device clear, empties the fifo and ends serial poll, addressed or not
// - 0x18 enters serial poll, 0x19 leaves serial poll
// - addressed commands act only while we are listen-addressed; 0x08 also acts unaddressed when the trigger option is set
// - 0x04 when listening is a selective clear to defaults
// - 0x01 when listening drops lockout; remote clears for one cycle, then REN sets it again
// - 0x08 under ATN fires trigger; option lets it fire unaddressed
// - 0x3F clears listener, 0x5F clears talker
// - listen address is 0x20 plus own address
// - talk address is 0x40 plus own address and makes us talker
// - secondary command group bytes are ignored
// - decoding looks at seven low data bits only
// - data accepted only with ATN high after being listen-addressed
// - every bus line is active low at the pins
// - interlocked three-wire handshake on DAV, NRFD, NDAC
// - primary address 0 to 30 captured once after reset release
`timescale 1ns/1ps
`default_nettype none
module gcd_decoder (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic atn_n_i,
  input wire logic ifc_n_i,
  input wire logic ren_n_i,
  input wire logic eoi_n_i,
  input wire logic dav_n_i,
  input wire logic [7:0] dio_n_i,
  output logic nrfd_n_o,
  output logic nrfd_oe_n_o,
  output logic ndac_n_o,
  output logic ndac_oe_n_o,
  output logic srq_n_o,
  output logic srq_oe_n_o,
  input wire logic [4:0] addr_sw_i,
  input wire logic trig_unaddr_en_i,
  input wire logic service_req_i,
  output logic remote_o,
  output logic lockout_o,
  output logic poll_mode_o,
  output logic listener_o,
  output logic talker_o,
  output logic dev_clear_o,
  output logic trigger_o,
  output logic data_valid_o,
  input wire logic data_ready_i,
  output logic [7:0] data_o,
  output logic data_last_o
);
  typedef struct packed {
    gcd_pkg::gcd_hs_t hs;
    logic addr_taken;
    logic [4:0] addr;
    logic addr_ok;
    logic remote;
    logic lockout;
    logic poll;
    logic listen;
    logic talk;
    logic clr_pulse;
    logic trig_pulse;
    logic nrfd_n;
    logic ndac_n;
    logic srq_n;
    logic out_valid;
    logic [8:0] out_word;
  } gcd_state_t;

  // power-up values in one place; both handshake lines held low so the bus waits for us
  localparam gcd_state_t RESET_ST = '{
    hs: gcd_pkg::GCD_HS_IDLE,
    addr_taken: 1'b0,
    addr: 5'h00,
    addr_ok: 1'b0,
    remote: 1'b0,
    lockout: 1'b0,
    poll: 1'b0,
    listen: 1'b0,
    talk: 1'b0,
    clr_pulse: 1'b0,
    trig_pulse: 1'b0,
    nrfd_n: 1'b0,
    ndac_n: 1'b0,
    srq_n: 1'b1,
    out_valid: 1'b0,
    out_word: 9'h000
  };

  gcd_state_t st_reg;
  gcd_state_t st_next;

  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [8:0] fifo_out_data;
  logic fifo_push;
  logic fifo_pop;
  logic [8:0] fifo_in_data;

  // two-bit group of a 7-bit code: listen, talk, other
  function automatic logic [1:0] code_group(input logic [6:0] c);
    if (c[6:5] == LISTEN_BASE_HI()) begin
      code_group = gcd_pkg::GRP_LISTEN;
    end else if (c[6:5] == TALK_BASE_HI()) begin
      code_group = gcd_pkg::GRP_TALK;
    end else begin
      code_group = 2'h0;
    end
  endfunction

  function automatic logic [1:0] LISTEN_BASE_HI();
    LISTEN_BASE_HI = gcd_pkg::LISTEN_BASE[6:5];
  endfunction

  function automatic logic [1:0] TALK_BASE_HI();
    TALK_BASE_HI = gcd_pkg::TALK_BASE[6:5];
  endfunction

  logic atn;
  logic ifc;
  logic ren;
  logic eoi;
  logic dav;
  logic [6:0] code;
  // pins are active low; invert once here
  assign atn = !atn_n_i;
  assign ifc = !ifc_n_i;
  assign ren = !ren_n_i;
  assign eoi = !eoi_n_i;
  assign dav = !dav_n_i;
  assign code = ~dio_n_i[6:0];

  always_comb begin
    logic byte_now;
    logic [1:0] grp;
    logic blocked;
    byte_now = 1'b0;
    grp = code_group(code);
    // a data byte for us with nowhere to go must not see NRFD released
    blocked = !atn && st_reg.listen && !fifo_in_ready;
    st_next = st_reg;
    st_next.clr_pulse = 1'b0;
    st_next.trig_pulse = 1'b0;
    fifo_push = 1'b0;
    fifo_in_data = {eoi, ~dio_n_i};
    // address switches read once only, after reset release
    if (!st_reg.addr_taken) begin
      st_next.addr_taken = 1'b1;
      st_next.addr = addr_sw_i;
      st_next.addr_ok = (addr_sw_i <= gcd_pkg::ADDR_MAX);
    end
    // acceptor handshake
    case (st_reg.hs)
      gcd_pkg::GCD_HS_IDLE: begin
        st_next.ndac_n = 1'b0;
        if (!dav && st_reg.addr_taken) begin
          st_next.nrfd_n = !blocked;
          st_next.hs = gcd_pkg::GCD_HS_READY;
        end
      end
      gcd_pkg::GCD_HS_READY: begin
        // data bytes stall here while the fifo is full, holding NRFD low
        if (dav && !blocked) begin
          byte_now = 1'b1;
          st_next.nrfd_n = 1'b0;
          st_next.ndac_n = 1'b1;
          st_next.hs = gcd_pkg::GCD_HS_TAKEN;
        end else begin
          st_next.nrfd_n = !blocked;
        end
      end
      gcd_pkg::GCD_HS_TAKEN: begin
        if (!dav) begin
          st_next.ndac_n = 1'b0;
          st_next.hs = gcd_pkg::GCD_HS_IDLE;
        end
      end
      default: begin
        st_next.hs = gcd_pkg::GCD_HS_IDLE;
      end
    endcase
    if (byte_now && atn) begin
      if (code == gcd_pkg::CMD_LOCKOUT) begin
        st_next.lockout = 1'b1;
      end else if (code == gcd_pkg::CMD_DEV_CLEAR) begin
        st_next.clr_pulse = 1'b1;
        st_next.poll = 1'b0;
      end else if (code == gcd_pkg::CMD_POLL_ON) begin
        st_next.poll = 1'b1;
      end else if (code == gcd_pkg::CMD_POLL_OFF) begin
        st_next.poll = 1'b0;
      end else if (code == gcd_pkg::CMD_SEL_CLEAR) begin
        if (st_reg.listen) begin
          st_next.clr_pulse = 1'b1;
          st_next.poll = 1'b0;
        end
      end else if (code == gcd_pkg::CMD_GO_LOCAL) begin
        if (st_reg.listen) begin
          st_next.remote = 1'b0;
          st_next.lockout = 1'b0;
        end
      end else if (code == gcd_pkg::CMD_TRIGGER) begin
        if (st_reg.listen || trig_unaddr_en_i) begin
          st_next.trig_pulse = 1'b1;
        end
      end else if (code == gcd_pkg::CMD_UNLISTEN) begin
        st_next.listen = 1'b0;
      end else if (code == gcd_pkg::CMD_UNTALK) begin
        st_next.talk = 1'b0;
      end else if (grp == gcd_pkg::GRP_LISTEN) begin
        if (st_reg.addr_ok &&
            code == (gcd_pkg::LISTEN_BASE | {2'h0, st_reg.addr})) begin
          st_next.listen = 1'b1;
        end
      end else if (grp == gcd_pkg::GRP_TALK) begin
        if (st_reg.addr_ok &&
            code == (gcd_pkg::TALK_BASE | {2'h0, st_reg.addr})) begin
          st_next.talk = 1'b1;
        end
      end
      // anything else, secondary group included, is dropped
    end else if (byte_now && st_reg.listen) begin
      fifo_push = 1'b1;
    end
    // remote follows REN; without REN the device is always local
    if (ren) begin
      if (!st_reg.remote && !(byte_now && atn && code == gcd_pkg::CMD_GO_LOCAL &&
          st_reg.listen)) begin
        st_next.remote = 1'b1;
      end
    end else begin
      st_next.remote = 1'b0;
      st_next.lockout = 1'b0;
    end
    if (ifc) begin
      st_next.listen = 1'b0;
      st_next.talk = 1'b0;
    end
    st_next.srq_n = !(service_req_i && !st_reg.poll);
    // output register stage fed from the fifo
    fifo_pop = fifo_out_valid && (!st_reg.out_valid || data_ready_i);
    if (fifo_pop) begin
      st_next.out_valid = 1'b1;
      st_next.out_word = fifo_out_data;
    end else if (data_ready_i) begin
      st_next.out_valid = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_reg <= RESET_ST;
    end else begin
      st_reg <= st_next;
    end
  end

  gcd_fifo #(
    .WIDTH(9),
    .DEPTH(gcd_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .clear_i(st_reg.clr_pulse),
    .in_valid_i(fifo_push),
    .in_ready_o(fifo_in_ready),
    .in_data_i(fifo_in_data),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_pop),
    .out_data_o(fifo_out_data)
  );

  // open-drain drivers: enable low while driving low
  assign nrfd_n_o = 1'b0;
  assign nrfd_oe_n_o = st_reg.nrfd_n;
  assign ndac_n_o = 1'b0;
  assign ndac_oe_n_o = st_reg.ndac_n;
  assign srq_n_o = 1'b0;
  assign srq_oe_n_o = st_reg.srq_n;
  assign remote_o = st_reg.remote;
  assign lockout_o = st_reg.lockout;
  assign poll_mode_o = st_reg.poll;
  assign listener_o = st_reg.listen;
  assign talker_o = st_reg.talk;
  assign dev_clear_o = st_reg.clr_pulse;
  assign trigger_o = st_reg.trig_pulse;
  assign data_valid_o = st_reg.out_valid;
  assign data_o = st_reg.out_word[7:0];
  assign data_last_o = st_reg.out_word[8];
endmodule
`default_nettype wire

// ### design/gcd_fifo.sv
// small valid/ready fifo for received data bytes
`timescale 1ns/1ps
`default_nettype none
module gcd_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 4
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic clear_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW-1:0] wp_reg;
  logic [PW-1:0] rp_reg;
  logic [PW:0] cnt_reg;
  logic push;
  logic pop;
  assign in_ready_o = (cnt_reg != (PW+1)'(DEPTH));
  assign out_valid_o = (cnt_reg != '0);
  assign out_data_o = mem_reg[rp_reg];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
    end else if (clear_i) begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wp_reg <= wp_reg + 1'b1;
      end
      if (pop) begin
        rp_reg <= rp_reg + 1'b1;
      end
      cnt_reg <= cnt_reg + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
  // storage has no reset; contents are only read when counted valid
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_reg[wp_reg] <= in_data_i;
    end
  end
endmodule
`default_nettype wire

// ### verification/gcd_ctrl_model.sv
// bus controller model: uniline levels and source side of the handshake
`timescale 1ns/1ps
`default_nettype none
module gcd_ctrl_model (
  input wire logic clk_i,
  input wire logic nrfd_oe_n_i,
  input wire logic ndac_oe_n_i,
  output logic atn_n_o,
  output logic ifc_n_o,
  output logic ren_n_o,
  output logic eoi_n_o,
  output logic dav_n_o,
  output logic [7:0] dio_n_o
);
  // released lines float high through the bus pull-ups
  initial begin
    atn_n_o = 1'b1;
    ifc_n_o = 1'b1;
    ren_n_o = 1'b1;
    eoi_n_o = 1'b1;
    dav_n_o = 1'b1;
    dio_n_o = 8'hFF;
  end
  // one byte per handshake; wait_max bounds a stall so refusals return
  task automatic send(input logic atn, input logic [7:0] b, input logic last,
    input int wait_max, output logic ok);
    int n;
    n = 0;
    @(negedge clk_i);
    atn_n_o = ~atn;
    @(negedge clk_i);
    while (nrfd_oe_n_i !== 1'b1 && n < wait_max) begin
      @(negedge clk_i);
      n++;
    end
    ok = (nrfd_oe_n_i === 1'b1);
    if (ok) begin
      dio_n_o = ~b;
      eoi_n_o = ~last;
      repeat ($urandom_range(2)) @(negedge clk_i);
      dav_n_o = 1'b0;
      n = 0;
      do begin
        @(posedge clk_i);
        n++;
      end while (ndac_oe_n_i !== 1'b1 && n < 200);
      ok = (ndac_oe_n_i === 1'b1);
      @(negedge clk_i);
      dav_n_o = 1'b1;
      eoi_n_o = 1'b1;
      dio_n_o = 8'hFF;
    end
  endtask
endmodule
`default_nettype wire

// ### verification/gcd_decoder_properties.sv
// concurrent checks on the decoder's bus and user ports
`timescale 1ns/1ps
`default_nettype none
module gcd_decoder_properties (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic ren_n_i,
  input wire logic ifc_n_i,
  input wire logic dav_n_i,
  input wire logic service_req_i,
  input wire logic data_ready_i,
  input wire logic nrfd_n_o,
  input wire logic nrfd_oe_n_o,
  input wire logic ndac_n_o,
  input wire logic ndac_oe_n_o,
  input wire logic srq_n_o,
  input wire logic srq_oe_n_o,
  input wire logic remote_o,
  input wire logic lockout_o,
  input wire logic poll_mode_o,
  input wire logic listener_o,
  input wire logic talker_o,
  input wire logic dev_clear_o,
  input wire logic trigger_o,
  input wire logic data_valid_o,
  input wire logic [7:0] data_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);
  sequence s_taken;
    !ndac_oe_n_o ##1 ndac_oe_n_o;
  endsequence
  sequence s_dav_gone;
    dav_n_i [*5];
  endsequence
  AST_TAKEN_NRFD: assert property (s_taken |-> !nrfd_oe_n_o)
    else $error("nrfd released while byte taken");
  AST_NDAC_STANDS: assert property (ndac_oe_n_o && !dav_n_i |=> ndac_oe_n_o)
    else $error("ndac dropped before dav false");
  AST_NDAC_BACK: assert property (s_dav_gone |-> !ndac_oe_n_o)
    else $error("ndac not reasserted after dav false");
  AST_NRFD_AFTER: assert property ($fell(ndac_oe_n_o) |-> !nrfd_oe_n_o)
    else $error("nrfd released with ndac");
  AST_PINS_LOW: assert property (!nrfd_n_o && !ndac_n_o && !srq_n_o)
    else $error("open drain pin not low");
  AST_SRQ_IDLE: assert property (!service_req_i [*3] |-> srq_oe_n_o)
    else $error("srq pulled without request");
  AST_SRQ_POLL: assert property (poll_mode_o [*3] |-> srq_oe_n_o)
    else $error("srq pulled in poll mode");
  AST_REN_LOCAL: assert property (ren_n_i [*4] |-> !remote_o && !lockout_o)
    else $error("remote without ren");
  AST_IFC_IDLE: assert property (!ifc_n_i [*4] |-> !listener_o && !talker_o)
    else $error("role kept under ifc");
  AST_CLR_PULSE: assert property (dev_clear_o |=> !dev_clear_o)
    else $error("clear pulse too long");
  AST_TRIG_PULSE: assert property (trigger_o |=> !trigger_o)
    else $error("trigger pulse too long");
  AST_STREAM_HOLD: assert property (data_valid_o && !data_ready_i && !dev_clear_o |=>
    dev_clear_o || (data_valid_o && $stable(data_o)))
    else $error("stream word changed before taken");
endmodule
bind gcd_decoder gcd_decoder_properties PROPS (.clk_i(clk_i), .rstn_i(rstn_i),
  .ren_n_i(ren_n_i), .ifc_n_i(ifc_n_i), .dav_n_i(dav_n_i), .service_req_i(service_req_i),
  .data_ready_i(data_ready_i), .nrfd_n_o(nrfd_n_o), .nrfd_oe_n_o(nrfd_oe_n_o),
  .ndac_n_o(ndac_n_o), .ndac_oe_n_o(ndac_oe_n_o), .srq_n_o(srq_n_o), .srq_oe_n_o(srq_oe_n_o),
  .remote_o(remote_o), .lockout_o(lockout_o), .poll_mode_o(poll_mode_o),
  .listener_o(listener_o), .talker_o(talker_o), .dev_clear_o(dev_clear_o),
  .trigger_o(trigger_o), .data_valid_o(data_valid_o), .data_o(data_o));
`default_nettype wire

// ### verification/gcd_decoder_tb.sv
// self-checking bench for the command decoder
`timescale 1ns/1ps
`default_nettype none
module gcd_decoder_tb;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [4:0] addr = 5'h00;
  logic trig_en = 1'b0;
  logic srv = 1'b0;
  logic rdy = 1'b0;
  logic drain = 1'b0;
  logic atn_n, ifc_n, ren_n, eoi_n, dav_n, ok;
  logic [7:0] dio_n, data;
  logic nrfd_oe_n, ndac_oe_n, nrfd_n, ndac_n, srq_n, srq_oe_n;
  logic remote, lockout, poll, listener, talker, dclr, trig, dvalid, dlast;
  logic [8:0] exp_q[$];
  int bad_count = 0;
  int n_tests = 0;
  int n_clr = 0;
  int n_trig = 0;
  initial forever #25 clk_i = ~clk_i;
  gcd_ctrl_model CTRL (.clk_i(clk_i), .nrfd_oe_n_i(nrfd_oe_n), .ndac_oe_n_i(ndac_oe_n),
    .atn_n_o(atn_n), .ifc_n_o(ifc_n), .ren_n_o(ren_n), .eoi_n_o(eoi_n), .dav_n_o(dav_n),
    .dio_n_o(dio_n));
  gcd_decoder DUT (.clk_i(clk_i), .rstn_i(rstn_i), .atn_n_i(atn_n), .ifc_n_i(ifc_n),
    .ren_n_i(ren_n), .eoi_n_i(eoi_n), .dav_n_i(dav_n), .dio_n_i(dio_n), .nrfd_n_o(nrfd_n),
    .nrfd_oe_n_o(nrfd_oe_n), .ndac_n_o(ndac_n), .ndac_oe_n_o(ndac_oe_n), .srq_n_o(srq_n),
    .srq_oe_n_o(srq_oe_n), .addr_sw_i(addr), .trig_unaddr_en_i(trig_en),
    .service_req_i(srv), .remote_o(remote), .lockout_o(lockout), .poll_mode_o(poll),
    .listener_o(listener), .talker_o(talker), .dev_clear_o(dclr), .trigger_o(trig),
    .data_valid_o(dvalid), .data_ready_i(rdy), .data_o(data), .data_last_o(dlast));
  task automatic chk(input string name, input logic exp, input logic got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %b seen %b", name, exp, got);
    end
  endtask
  task automatic chk9(input string name, input logic [8:0] exp, input logic [8:0] got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic chk_n(input string name, input int exp, input int got);
    n_tests++;
    if (got != exp) begin
      bad_count++;
      $display("Error %s expected %0d seen %0d", name, exp, got);
    end
  endtask
  task automatic put(input logic atn, input logic [7:0] b, input logic last);
    CTRL.send(atn, b, last, 200, ok);
    chk("handshake", 1'b1, ok);
  endtask
  task automatic cmd(input logic [7:0] b);
    put(1'b1, b, 1'b0);
    repeat (3) @(negedge clk_i);
  endtask
  task automatic print_verdict;
    if (bad_count == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  always @(negedge clk_i) rdy <= drain & 1'($urandom_range(1));
  always @(posedge clk_i) begin
    if (dclr === 1'b1) n_clr++;
    if (trig === 1'b1) n_trig++;
    if (dvalid === 1'b1 && rdy === 1'b1) begin
      if (exp_q.size() == 0) chk("stray data", 1'b0, dvalid);
      else chk9("data", exp_q.pop_front(), {dlast, data});
    end
  end
  initial begin
    int i;
    int refused;
    logic [7:0] b;
    void'($urandom(52));
    addr = 5'($urandom_range(30));
    repeat (16) @(negedge clk_i);
    rstn_i = 1'b1;
    repeat (3) @(negedge clk_i);
    chk("remote", 1'b0, remote);
    CTRL.ren_n_o = 1'b0;
    repeat (5) @(negedge clk_i);
    chk("remote", 1'b1, remote);
    cmd(8'h11);
    chk("lockout", 1'b1, lockout);
    put(1'b0, 8'h41, 1'b0);
    cmd(8'h04);
    chk_n("clear", 0, n_clr);
    cmd(8'h3F);
    cmd({3'b101, addr}); // bit 7 set must not matter
    chk("listener", 1'b1, listener);
    cmd({3'b011, addr});
    chk("listener", 1'b1, listener);
    cmd(8'h01);
    chk("lockout", 1'b0, lockout);
    cmd(8'h04);
    chk_n("clear", 1, n_clr);
    cmd(8'h14);
    chk_n("clear", 2, n_clr);
    drain = 1'b1;
    for (i = 0; i < 6; i++) begin
      b = 8'($urandom);
      exp_q.push_back({i == 5, b});
      put(1'b0, b, i == 5);
    end
    repeat (20) @(negedge clk_i);
    chk_n("drained", 0, exp_q.size());
    drain = 1'b0;
    refused = 0;
    // the far side stalls: bytes pile up until nrfd stays held
    for (i = 0; i < 8; i++) begin
      b = 8'($urandom);
      CTRL.send(1'b0, b, 1'b0, 20, ok);
      if (ok) exp_q.push_back({1'b0, b});
      else refused++;
    end
    chk("refused", 1'b1, refused > 0);
    drain = 1'b1;
    repeat (30) @(negedge clk_i);
    chk_n("drained", 0, exp_q.size());
    cmd({3'b010, addr});
    chk("talker", 1'b1, talker);
    cmd(8'h5F);
    chk("talker", 1'b0, talker);
    cmd(8'h3F);
    chk("listener", 1'b0, listener);
    put(1'b0, 8'h55, 1'b0);
    for (i = 0; i < 2; i++) begin
      trig_en = i[0];
      n_trig = 0;
      cmd(8'h08);
      chk_n("trigger", i, n_trig);
    end
    srv = 1'b1;
    cmd(8'h18);
    chk("poll", 1'b1, poll);
    chk("srq", 1'b1, srq_oe_n);
    cmd(8'h19);
    chk("poll", 1'b0, poll);
    chk("srq", 1'b0, srq_oe_n);
    srv = 1'b0;
    cmd({3'b001, addr});
    cmd({3'b010, addr});
    CTRL.ifc_n_o = 1'b0;
    repeat (5) @(negedge clk_i);
    chk("listener", 1'b0, listener);
    chk("talker", 1'b0, talker);
    CTRL.ifc_n_o = 1'b1;
    CTRL.ren_n_o = 1'b1;
    repeat (5) @(negedge clk_i);
    chk("remote", 1'b0, remote);
    print_verdict();
  end
  initial begin
    #2000000;
    bad_count++;
    print_verdict();
  end
endmodule
`default_nettype wire
